/* inc/dt8_params.svh */
`ifndef DT8_PARAMS_SVH
`define DT8_PARAMS_SVH

// ==========================================================================
// Bus geometry
`define DT8_ADDR_W     20
`define DT8_IDX_W      16

// ==========================================================================
// Register indices (byte address is four times the index)
`define DT8_IDX_CMP0   16'hf300
`define DT8_IDX_CMP1   16'hf301
`define DT8_IDX_CNT0   16'hf310
`define DT8_IDX_CNT1   16'hf311
`define DT8_IDX_CTL0   16'hf320
`define DT8_IDX_CTL1   16'hf321
`define DT8_IDX_START  16'hf330
`define DT8_IDX_STOP   16'hf332
`define DT8_IDX_STAT   16'hf334

// ==========================================================================
// Reset values and fixed values
`define DT8_CMP_RST    8'hff
`define DT8_CNT_RST    8'h00
`define DT8_CTL_RST    8'h00
`define DT8_CMP_MIN    8'h01
`define DT8_CNT_MAX    8'hff
`define DT8_ZERO8      8'h00

// ==========================================================================
// Control fields
`define DT8_B_OST      7
`define DT8_B_CHAIN    6
`define DT8_B_DIV_HI   5
`define DT8_B_DIV_LO   3
`define DT8_B_CS       0
`define DT8_CTL0_MASK  8'hf9
`define DT8_CTL1_MASK  8'hb9
`define DT8_DIV_RSVD   3'h7
`define DT8_PRE_MIN_W  6

`endif

/* inc/dt8_pkg.sv */
`include "dt8_params.svh"

package dt8_pkg;

  // ========================================================================
  // Wishbone request from the master
  typedef struct packed {
    logic                   cyc;
    logic                   stb;
    logic                   we;
    logic [`DT8_ADDR_W-1:0] adr;
    logic [3:0]             sel;
    logic [31:0]            dat;
  } dt8_wb_req_s;

  // ========================================================================
  // Run state of one timer
  typedef enum logic [2:0] {
    DT8_IDLE     = 3'b001,
    DT8_RUN      = 3'b010,
    DT8_STOPPING = 3'b100
  } dt8_run_e;

endpackage

/* core/dt8_timer.sv */
// The Wishbone slave port was decided locally.
`timescale 1ns/10ps
`include "dt8_params.svh"

// Notes on behaviour
// - Counter equal to compare value raises that timer's match interrupt.
// - Writing zero to a compare register stores one instead.
// - Any write to a counter register clears that counter.
// - Chained, a write to either counter byte clears both bytes.
// - Control bit 7 selects auto-reload (0) or one-shot (1).
// - Timer 0 control bit 6 joins both timers into one 16-bit timer.
// - Chained, timer 1 steps on each timer 0 overflow.
// - Chained, timer 0 match interrupt is suppressed; 16-bit match fires.
// - Control bits 5..3 divide the clock by 1..64; 111 is undivided.
// - Control bit 0 picks slow (0) or fast oscillator (1) clock.
// - Chained, timer 0 clock source wins, timer 1 source ignored.
// - Unchained, start bit 1 starts timer 1.
// - Chained, the timer 1 start bit does nothing.
// - Writing zero to a start bit leaves running state alone.
// - On match: interrupt at that tick, counter back to zero, keeps counting.
// - After stop, counter advances once more on next tick, then halts.
// - A restarted timer resumes from the value it held.
// - One-shot: running flag clears on match, stopping the timer.

module dt8_timer #(
  parameter int PRESCALE_W = 6
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire dt8_pkg::dt8_wb_req_s wb_req,
  output logic                      wb_ack,
  output logic [31:0]               wb_rdata,
  input  wire logic                 low_speed_clock,
  input  wire logic                 oscillator_fast_clock,
  output logic [1:0]                match_interrupt
);
  import dt8_pkg::*;

  // ========================================================================
  // Elaboration check
  if (PRESCALE_W < `DT8_PRE_MIN_W) begin : g_bad_width
    $error("PRESCALE_W too small for divide by 64");
  end

  // ========================================================================
  // Helpers
  function automatic logic reg_hit(input logic [`DT8_ADDR_W-1:0] adr,
                                   input logic [`DT8_IDX_W-1:0]  idx);
    reg_hit = (adr[`DT8_ADDR_W-1:2] == (`DT8_ADDR_W-2)'(idx));
  endfunction

  // Mask of prescaler bits that must all be one for a divided tick
  function automatic logic [PRESCALE_W-1:0] div_mask(input logic [2:0] d);
    logic [PRESCALE_W:0] one;
    one = (PRESCALE_W+1)'(1);
    if (d == `DT8_DIV_RSVD)
      div_mask = '0;
    else
      div_mask = PRESCALE_W'((one << d) - one);
  endfunction

  // ========================================================================
  // Bus slave
  logic                   ack_r;
  logic [31:0]            rdata_r;
  logic [7:0]             cmp_r [2];
  logic [7:0]             cnt_r [2];
  logic [7:0]             ctl_r [2];
  dt8_run_e               st_r  [2];
  logic [1:0]             irq_r;
  logic                   ls_q;
  logic                   os_q;
  logic [PRESCALE_W-1:0]  pre_r [2];

  logic                   req;
  logic                   wr;
  logic [7:0]             wdat;
  logic [1:0]             wr_cmp;
  logic [1:0]             wr_cnt;
  logic [1:0]             wr_ctl;
  logic                   wr_start;
  logic                   wr_stop;
  logic                   chain;
  logic [1:0]             src_fall;
  logic [1:0]             tick;
  logic [1:0]             cnt_on;
  logic [1:0]             adv;
  logic [1:0]             hit;
  logic [1:0]             clr;
  logic [1:0]             start;
  logic [1:0]             stop;
  logic [1:0]             ost;
  logic                   m16;
  logic [1:0]             m8;
  logic [7:0]             status;
  logic [7:0]             rmux;

  // Answer one cycle after the request; ack drops in the following cycle
  assign req  = wb_req.cyc & wb_req.stb & ~ack_r;
  assign wr   = req & wb_req.we & wb_req.sel[0];
  assign wdat = wb_req.dat[7:0];

  assign wr_cmp[0] = wr & reg_hit(wb_req.adr, `DT8_IDX_CMP0);
  assign wr_cmp[1] = wr & reg_hit(wb_req.adr, `DT8_IDX_CMP1);
  assign wr_cnt[0] = wr & reg_hit(wb_req.adr, `DT8_IDX_CNT0);
  assign wr_cnt[1] = wr & reg_hit(wb_req.adr, `DT8_IDX_CNT1);
  assign wr_ctl[0] = wr & reg_hit(wb_req.adr, `DT8_IDX_CTL0);
  assign wr_ctl[1] = wr & reg_hit(wb_req.adr, `DT8_IDX_CTL1);
  assign wr_start  = wr & reg_hit(wb_req.adr, `DT8_IDX_START);
  assign wr_stop   = wr & reg_hit(wb_req.adr, `DT8_IDX_STOP);

  assign status = {6'h00,
                   (st_r[1] != DT8_IDLE) & ~chain,
                   (st_r[0] != DT8_IDLE)};

  always_comb begin
    rmux = `DT8_ZERO8;
    if (reg_hit(wb_req.adr, `DT8_IDX_CMP0)) rmux = cmp_r[0];
    if (reg_hit(wb_req.adr, `DT8_IDX_CMP1)) rmux = cmp_r[1];
    if (reg_hit(wb_req.adr, `DT8_IDX_CNT0)) rmux = cnt_r[0];
    if (reg_hit(wb_req.adr, `DT8_IDX_CNT1)) rmux = cnt_r[1];
    if (reg_hit(wb_req.adr, `DT8_IDX_CTL0)) rmux = ctl_r[0];
    if (reg_hit(wb_req.adr, `DT8_IDX_CTL1)) rmux = ctl_r[1];
    if (reg_hit(wb_req.adr, `DT8_IDX_STAT)) rmux = status;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= req;
      if (req) begin
        rdata_r <= {24'h00_0000, rmux};
      end
    end
  end

  assign wb_ack   = ack_r;
  assign wb_rdata = rdata_r;

  // ========================================================================
  // Control registers and chain select
  assign chain = ctl_r[0][`DT8_B_CHAIN];

  always_ff @(posedge clk) begin
    if (rst) begin
      ctl_r[0] <= `DT8_CTL_RST;
      ctl_r[1] <= `DT8_CTL_RST;
    end else begin
      if (wr_ctl[0]) begin
        ctl_r[0] <= wdat & `DT8_CTL0_MASK;
      end
      if (wr_ctl[1]) begin
        ctl_r[1] <= wdat & `DT8_CTL1_MASK;
      end
    end
  end

  // ========================================================================
  // Clock edges of the two timer clock sources
  always_ff @(posedge clk) begin
    if (rst) begin
      ls_q <= 1'b0;
      os_q <= 1'b0;
    end else begin
      ls_q <= low_speed_clock;
      os_q <= oscillator_fast_clock;
    end
  end

  // Chained: timer 0 source also feeds timer 1
  assign src_fall[0] = ctl_r[0][`DT8_B_CS] ?
                       (os_q & ~oscillator_fast_clock) :
                       (ls_q & ~low_speed_clock);
  assign src_fall[1] = (chain ? ctl_r[0][`DT8_B_CS] :
                        ctl_r[1][`DT8_B_CS]) ?
                       (os_q & ~oscillator_fast_clock) :
                       (ls_q & ~low_speed_clock);

  // ========================================================================
  // Chaining terms
  assign m8[0] = (cnt_r[0] == cmp_r[0]);
  assign m8[1] = (cnt_r[1] == cmp_r[1]);
  assign m16   = m8[0] & m8[1];

  assign adv[0] = tick[0] & cnt_on[0];
  assign adv[1] = chain ?
                  (adv[0] & (cnt_r[0] == `DT8_CNT_MAX) & ~m16) :
                  (tick[1] & cnt_on[1]);
  assign hit[0] = adv[0] & (chain ? m16 : m8[0]);
  assign hit[1] = chain ? hit[0] : (adv[1] & m8[1]);
  assign ost[0] = ctl_r[0][`DT8_B_OST];
  assign ost[1] = chain ? ctl_r[0][`DT8_B_OST] :
                  ctl_r[1][`DT8_B_OST];
  assign clr[0] = wr_cnt[0] | (chain & wr_cnt[1]);
  assign clr[1] = wr_cnt[1] | (chain & wr_cnt[0]);
  // Zero written to a start bit is no request at all
  assign start[0] = wr_start & wdat[0];
  assign start[1] = wr_start & wdat[1] & ~chain;
  assign stop[0]  = wr_stop & wdat[0];
  assign stop[1]  = wr_stop & wdat[1] & ~chain;

  // ========================================================================
  // Per-timer prescaler, counter, compare and run state
  for (genvar i = 0; i < 2; i++) begin : g_tmr
    logic [2:0]            div;
    logic [PRESCALE_W-1:0] msk;

    assign div = ctl_r[i][`DT8_B_DIV_HI:`DT8_B_DIV_LO];
    assign msk = div_mask(div);
    // Prescaler runs free, so the first tick after start may be early
    assign tick[i] = src_fall[i] & ((pre_r[i] & msk) == msk);
    assign cnt_on[i] = (st_r[i] != DT8_IDLE);

    always_ff @(posedge clk) begin
      if (rst) begin
        pre_r[i] <= '0;
      end else if (src_fall[i]) begin
        pre_r[i] <= pre_r[i] + PRESCALE_W'(1);
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        cmp_r[i] <= `DT8_CMP_RST;
      end else if (wr_cmp[i]) begin
        cmp_r[i] <= (wdat == `DT8_ZERO8) ? `DT8_CMP_MIN : wdat;
      end
    end

    // Counter holds its value while idle so a restart resumes from it
    always_ff @(posedge clk) begin
      if (rst) begin
        cnt_r[i] <= `DT8_CNT_RST;
      end else if (clr[i]) begin
        cnt_r[i] <= `DT8_CNT_RST;
      end else if (hit[i]) begin
        cnt_r[i] <= `DT8_CNT_RST;
      end else if (adv[i]) begin
        cnt_r[i] <= cnt_r[i] + 8'h01;
      end
    end

    // A start arriving with a hardware stop in the same cycle wins
    always_ff @(posedge clk) begin
      if (rst) begin
        st_r[i] <= DT8_IDLE;
      end else if (i == 1 && chain) begin
        st_r[i] <= DT8_IDLE;
      end else begin
        unique case (st_r[i])
          DT8_IDLE: begin
            if (start[i]) begin
              st_r[i] <= DT8_RUN;
            end
          end
          DT8_RUN: begin
            if (stop[i]) begin
              st_r[i] <= DT8_STOPPING;
            end else if (hit[i] && ost[i] && !start[i]) begin
              st_r[i] <= DT8_IDLE;
            end
          end
          DT8_STOPPING: begin
            if (start[i]) begin
              st_r[i] <= DT8_RUN;
            end else if (adv[i] || (i == 0 && tick[0])) begin
              st_r[i] <= DT8_IDLE;
            end
          end
          default: begin
            st_r[i] <= DT8_IDLE;
          end
        endcase
      end
    end
  end

  // ========================================================================
  // Match interrupts, one clock pulse each
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_r <= 2'b00;
    end else begin
      irq_r[0] <= hit[0] & ~chain;
      irq_r[1] <= hit[1];
    end
  end

  assign match_interrupt = irq_r;

  // ========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic raw_m0;
  assign raw_m0 = tick[0] & (st_r[0] != DT8_IDLE) & ~chain &
                  (cnt_r[0] == cmp_r[0]) & ~wr_cnt[0];

  a_match_irq_pulse: assert property (
    raw_m0 |=> match_interrupt[0] ##1 !match_interrupt[0] || raw_m0)
    else $error("timer 0 match gave no interrupt pulse");

  a_match_cnt_zero: assert property (
    raw_m0 |=> cnt_r[0] == `DT8_CNT_RST)
    else $error("timer 0 counter not zero after match");

  a_cmp_zero_one: assert property (
    wr_cmp[1] && wdat == `DT8_ZERO8 |=> cmp_r[1] == `DT8_CMP_MIN)
    else $error("zero compare write not stored as one");

  a_cnt_write_clr: assert property (
    wr_cnt[1] |=> cnt_r[1] == `DT8_CNT_RST)
    else $error("counter write did not clear");

  a_chain_both_clr: assert property (
    chain && wr_cnt[1] |=> cnt_r[0] == `DT8_CNT_RST &&
                           cnt_r[1] == `DT8_CNT_RST)
    else $error("chained counter write left a byte");

  a_chain_no_irq0: assert property (
    chain && $past(chain) |-> !match_interrupt[0])
    else $error("timer 0 interrupt while chained");

  a_chain_carry: assert property (
    chain && adv[0] && cnt_r[0] == `DT8_CNT_MAX && !m16 &&
    !clr[1] |=> cnt_r[1] == $past(cnt_r[1]) + 8'h01)
    else $error("timer 1 missed timer 0 carry");

  a_oneshot_halt: assert property (
    !chain && ost[0] && st_r[0] == DT8_RUN && hit[0] &&
    !start[0] && !stop[0] |=> st_r[0] == DT8_IDLE)
    else $error("one-shot did not stop on match");

  a_stop_after_tick: assert property (
    st_r[0] == DT8_STOPPING && !start[0] && !tick[0] |=>
    st_r[0] == DT8_STOPPING)
    else $error("stopped before the last tick");

  a_start1_chain: assert property (
    chain && $past(chain) |-> st_r[1] == DT8_IDLE)
    else $error("timer 1 runs while chained");

  a_zero_start: assert property (
    wr_start && !wdat[0] && st_r[0] == DT8_IDLE |=>
    st_r[0] == DT8_IDLE)
    else $error("zero start bit started timer 0");

  a_ack_one: assert property (
    wb_ack |=> !wb_ack)
    else $error("ack held longer than one cycle");

  c_irq0: cover property (match_interrupt[0]);
  c_irq_chain: cover property (chain && match_interrupt[1]);
  c_oneshot: cover property (st_r[0] == DT8_RUN && ost[0]
                             ##1 st_r[0] == DT8_IDLE);
  c_stopping: cover property (st_r[1] == DT8_STOPPING
                              ##1 st_r[1] == DT8_IDLE);

endmodule

/* tb/dual_eight_bit_timer_bench.sv */
`timescale 1ns/10ps
`include "dt8_params.svh"

module dual_eight_bit_timer_bench;
  import dt8_pkg::*;

  // ==========================================================================
  // Clock, reset and stimulus
  logic              clk;
  logic              rst;
  dt8_wb_req_s       wb_req;
  logic              wb_ack;
  logic [31:0]       wb_rdata;
  logic              low_speed_clock;
  logic              oscillator_fast_clock;
  logic [1:0]        match_interrupt;
  logic [2:0]        src_cnt;
  int                error_cnt;
  int                compares;
  int                irq0_cnt;
  int                irq1_cnt;
  logic [31:0]       q;
  int                c0;

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Slow source period 8 clk, fast source period 4 clk
  initial src_cnt = 3'h0;
  always @(posedge clk) src_cnt <= src_cnt + 3'h1;
  assign low_speed_clock       = src_cnt[2];
  assign oscillator_fast_clock = src_cnt[1];

  // Counted on the falling edge so the tally never races a task that
  // reads it right after the rising edge that showed a pulse
  always @(negedge clk) begin
    if (match_interrupt[0] === 1'b1) irq0_cnt++;
    if (match_interrupt[1] === 1'b1) irq1_cnt++;
  end

  dt8_timer #(
    .PRESCALE_W (6)
  ) dt8_timer_i (
    .clk                   (clk),
    .rst                   (rst),
    .wb_req                (wb_req),
    .wb_ack                (wb_ack),
    .wb_rdata              (wb_rdata),
    .low_speed_clock       (low_speed_clock),
    .oscillator_fast_clock (oscillator_fast_clock),
    .match_interrupt       (match_interrupt)
  );

  // ==========================================================================
  // Tasks
  task automatic wrap_up;
    $display("checks %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic xfer(input logic we, input logic [15:0] idx,
                      input logic [7:0] d);
    int n;
    @(posedge clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {2'b00, idx, 2'b00},
                sel: 4'h1, dat: {24'h0, d}};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    if (n >= 50) error_cnt++;
    q = wb_rdata;
    wb_req <= '0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask

  task automatic rd_chk(input logic [15:0] idx, input logic [7:0] exp);
    xfer(1'b0, idx, 8'h00);
    chk(q, {24'h0, exp});
  endtask

  // Waits for the next pulse; a missing pulse counts as a mismatch
  task automatic wait_irq(input int b, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (match_interrupt[b] !== 1'b1 && n < 5000);
    if (n >= 5000) error_cnt++;
  endtask

  task automatic period(input int b, input int exp);
    int n;
    wait_irq(b, n);
    wait_irq(b, n);
    chk(n, exp);
  endtask

  // Stop takes effect only at the next timer tick, so poll the status
  task automatic halt(input logic [7:0] mask);
    int n;
    wr(`DT8_IDX_STOP, mask);
    n = 0;
    do begin
      xfer(1'b0, `DT8_IDX_STAT, 8'h00);
      n++;
    end while ((q[7:0] & mask) != 8'h00 && n < 200);
    chk(q[7:0] & mask, 8'h00);
  endtask

  // ==========================================================================
  // Watchdog and main sequence
  initial begin
    repeat (80000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end

  initial begin
    rst = 1'b1;
    wb_req = '0;
    error_cnt = 0;
    compares = 0;
    irq0_cnt = 0;
    irq1_cnt = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd_chk(`DT8_IDX_CMP0, 8'hff);
    rd_chk(`DT8_IDX_CMP1, 8'hff);
    rd_chk(`DT8_IDX_CNT0, 8'h00);
    rd_chk(`DT8_IDX_CNT1, 8'h00);
    rd_chk(`DT8_IDX_CTL0, 8'h00);
    rd_chk(`DT8_IDX_CTL1, 8'h00);
    rd_chk(`DT8_IDX_STAT, 8'h00);
    rd_chk(16'hf302, 8'h00);
    wr(`DT8_IDX_CMP0, 8'h00);
    rd_chk(`DT8_IDX_CMP0, 8'h01);
    wr(`DT8_IDX_CMP1, 8'h00);
    rd_chk(`DT8_IDX_CMP1, 8'h01);
    wr(`DT8_IDX_CTL0, 8'hff);
    rd_chk(`DT8_IDX_CTL0, 8'hf9);
    wr(`DT8_IDX_CTL1, 8'hff);
    rd_chk(`DT8_IDX_CTL1, 8'hb9);
    wr(`DT8_IDX_CTL0, 8'h00);
    wr(`DT8_IDX_CTL1, 8'h00);
    // Every divider code, compare 1: two ticks per interrupt
    for (int d = 0; d < 8; d++) begin
      wr(`DT8_IDX_CNT0, 8'h00);
      wr(`DT8_IDX_CTL0, 8'(d << 3));
      wr(`DT8_IDX_START, 8'h01);
      rd_chk(`DT8_IDX_STAT, 8'h01);
      period(0, (d == 0 || d == 7) ? 16 : (16 << d));
      halt(8'h01);
    end
    wr(`DT8_IDX_CNT0, 8'h00);
    wr(`DT8_IDX_CMP0, 8'h03);
    wr(`DT8_IDX_CTL0, 8'h01);
    wr(`DT8_IDX_START, 8'h01);
    period(0, 16);
    halt(8'h01);
    // Timer 1 alone
    wr(`DT8_IDX_CMP1, 8'h02);
    wr(`DT8_IDX_START, 8'h02);
    rd_chk(`DT8_IDX_STAT, 8'h02);
    period(1, 24);
    wr(`DT8_IDX_START, 8'h00);
    rd_chk(`DT8_IDX_STAT, 8'h02);
    halt(8'h02);
    xfer(1'b0, `DT8_IDX_CNT1, 8'h00);
    c0 = q;
    repeat (40) @(posedge clk);
    rd_chk(`DT8_IDX_CNT1, c0[7:0]);
    wr(`DT8_IDX_CNT1, 8'h5a);
    rd_chk(`DT8_IDX_CNT1, 8'h00);
    // One-shot: one pulse, then the timer stops itself
    wr(`DT8_IDX_CNT0, 8'h00);
    wr(`DT8_IDX_CTL0, 8'h80);
    wr(`DT8_IDX_START, 8'h01);
    wait_irq(0, c0);
    c0 = irq0_cnt;
    repeat (200) @(posedge clk);
    chk(irq0_cnt, c0);
    rd_chk(`DT8_IDX_STAT, 8'h00);
    rd_chk(`DT8_IDX_CNT0, 8'h00);
    // Chained: compare 0x0101, timer 1 source setting ignored
    wr(`DT8_IDX_CNT0, 8'h00);
    wr(`DT8_IDX_CTL0, 8'h40);
    wr(`DT8_IDX_CTL1, 8'h01);
    wr(`DT8_IDX_CMP0, 8'h00);
    wr(`DT8_IDX_CMP1, 8'h01);
    wr(`DT8_IDX_START, 8'h03);
    rd_chk(`DT8_IDX_STAT, 8'h01);
    c0 = irq0_cnt;
    period(1, 2064);
    chk(irq0_cnt, c0);
    halt(8'h01);
    wr(`DT8_IDX_CNT1, 8'h33);
    rd_chk(`DT8_IDX_CNT0, 8'h00);
    rd_chk(`DT8_IDX_CNT1, 8'h00);
    wr(`DT8_IDX_START, 8'h02);
    rd_chk(`DT8_IDX_STAT, 8'h00);
    wrap_up();
  end
endmodule
